// File: rtl/afp_fault_ctrl.sv
// Fault protection and error flag logic of a four half-bridge power stage
`timescale 1ns/1ps
`include "afp_regs.svh"

// Overview of operation
// R1 - Any shutdown fault pulls shutdown flag low
// R2 - Warnings low above 125 and 100 degrees
// R3 - Reset low releases shutdown flag high
// R4 - Fault gives Hi-Z and shutdown flag at once
// R5 - Other faults self-recover; overload, thermal latch
// R6 - Group shutdown depends on output configuration
// R7 - Bootstrap undervoltage disables only its half-bridge
// R8 - Short test runs only at supply start-up
// R9 - Found short holds all Hi-Z until gone
// R10 - Short test: ground phase, then supply phase
// R11 - Test time scales with filter capacitance
// R12 - During test flag low, reset ignored
// R13 - Reset pulse never restarts the short test
// R14 - Short test skipped in single-ended mode
// R15 - 64-pin: two warnings plus thermal shutdown
// R16 - 44-pin: one warning plus thermal shutdown
// R17 - Thermal latch holds until reset asserted
// R18 - Power-on clear resets overload, holds circuits
// R19 - Supply undervoltage gives all Hi-Z, flag low
// R20 - Supply undervoltage recovers without reset
// R21 - Controller should watch warning and act
// R22 - Overload clears on reset rising edge only; code also clears it in st_por at power-on
// R23 - Reset low forces all half-bridges Hi-Z
// R24 - Open-drain flags drive low or release
module afp_fault_ctrl #(
    parameter int unsigned FILTER_CAP_UF   = `AFP_FILTER_CAP_UF,
    parameter int unsigned SHORT_PHASE_CYC =
        `AFP_SHORT_CYC_PER_UF * FILTER_CAP_UF / 2
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    // Control pins
    input  wire logic                    reset_pin_n,
    input  wire logic [`AFP_CFG_W-1:0]   cfg_pins,
    input  wire logic                    pkg_64pin,
    // Supply monitors, high when above threshold
    input  wire logic                    vdd_ok,
    input  wire logic [`AFP_NB-1:0]      gate_supply_ok,
    input  wire logic [`AFP_NB-1:0]      boot_ok,
    // Fault detectors
    input  wire logic [`AFP_NB-1:0]      overload_det,
    input  wire logic                    temp_above_100,
    input  wire logic                    temp_above_125,
    input  wire logic                    temp_above_155,
    input  wire logic [`AFP_NB-1:0]      short_to_gnd,
    input  wire logic [`AFP_NB-1:0]      short_to_pvdd,
    // Power stage control
    output logic [`AFP_NB-1:0]           hiz,
    output logic                         weak_pulldown,
    output logic                         short_test_gnd,
    output logic                         short_test_pvdd,
    // Open-drain flags
    output logic                         shutdown_flag_n_o,
    output logic                         shutdown_flag_n_oe,
    output logic                         temp_warning_n_o,
    output logic                         temp_warning_n_oe,
    output logic                         temp_warning_low_n_o,
    output logic                         temp_warning_low_n_oe,
    output logic                         temp_warning_high_n_o,
    output logic                         temp_warning_high_n_oe
);

    afp_sync_if sif ();

    afp_input_sync #(.W(`AFP_SYNC_W)) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .raw    ({pkg_64pin, cfg_pins, temp_above_155, temp_above_125,
                  temp_above_100, short_to_pvdd, short_to_gnd,
                  overload_det, boot_ok, gate_supply_ok, vdd_ok,
                  reset_pin_n}),
        .sif    (sif)
    );

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    function automatic afp_pkg::afp_cfg_t cfg_decode(
        input logic [`AFP_CFG_W-1:0] code);
        case (code)
            `AFP_CFG_PAR: cfg_decode = afp_pkg::afp_par;
            `AFP_CFG_SE:  cfg_decode = afp_pkg::afp_se;
            default:      cfg_decode = afp_pkg::afp_full;
        endcase
    endfunction : cfg_decode

    logic                 rst_n;
    logic                 vdd;
    logic [`AFP_NB-1:0]   gate;
    logic [`AFP_NB-1:0]   boot;
    logic [`AFP_NB-1:0]   ovl;
    logic [`AFP_NB-1:0]   shg;
    logic [`AFP_NB-1:0]   shp;
    logic                 t100;
    logic                 t125;
    logic                 t155;
    logic                 pkg64;
    afp_pkg::afp_cfg_t    cfg;

    assign rst_n = sif.lvl[`AFP_SY_RST];
    assign vdd   = sif.lvl[`AFP_SY_VDD];
    assign gate  = sif.lvl[`AFP_SY_GATE +: `AFP_NB];
    assign boot  = sif.lvl[`AFP_SY_BOOT +: `AFP_NB];
    assign ovl   = sif.lvl[`AFP_SY_OVL +: `AFP_NB];
    assign shg   = sif.lvl[`AFP_SY_SHG +: `AFP_NB];
    assign shp   = sif.lvl[`AFP_SY_SHP +: `AFP_NB];
    assign t100  = sif.lvl[`AFP_SY_T100];
    assign t125  = sif.lvl[`AFP_SY_T125];
    assign t155  = sif.lvl[`AFP_SY_T155];
    assign pkg64 = sif.lvl[`AFP_SY_PKG];
    assign cfg   = cfg_decode(sif.lvl[`AFP_SY_CFG +: `AFP_CFG_W]);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    afp_pkg::afp_st_t     st_ff;
    afp_pkg::afp_st_t     nxt_st;
    logic [31:0]          cnt_ff;
    logic [31:0]          nxt_cnt;
    logic                 rst_q_ff;
    logic [`AFP_NB-1:0]   ovl_latch_ff;
    logic [`AFP_NB-1:0]   nxt_ovl_latch;
    logic                 ote_ff;
    logic                 od_low_ff;
    logic [`AFP_NB-1:0]   nxt_hiz;
    logic                 nxt_sd;
    logic                 supplies_ok;
    logic                 supply_low_protect;
    logic                 testing;
    logic                 running;
    logic                 short_now;
    logic                 phase_done;
    logic                 rst_rise;
    logic                 grp_ab;
    logic                 grp_cd;
    logic                 glob_off;

    assign supplies_ok = vdd & (&gate);
    assign supply_low_protect         = ~supplies_ok;
    assign testing     = (st_ff == afp_pkg::st_gnd) ||
                         (st_ff == afp_pkg::st_pvdd);
    assign running     = (st_ff == afp_pkg::st_run);
    assign short_now   = (st_ff == afp_pkg::st_gnd)  ? |shg :
                         (st_ff == afp_pkg::st_pvdd) ? |shp : 1'b0;
    assign phase_done  = (cnt_ff >= 32'(SHORT_PHASE_CYC - 1)) & ~short_now;
    assign rst_rise    = rst_n & ~rst_q_ff;

    // ------------------------------------------------------------------
    // Start-up sequencer
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            afp_pkg::st_por: begin
                // R14 no test single-ended
                if (supplies_ok) begin
                    nxt_st = (cfg == afp_pkg::afp_se) ? afp_pkg::st_run
                                                      : afp_pkg::st_gnd;
                end
            end
            // R10 ground then supply
            afp_pkg::st_gnd: begin
                if (phase_done) begin
                    nxt_st = afp_pkg::st_pvdd;
                end
            end
            afp_pkg::st_pvdd: begin
                if (phase_done) begin
                    nxt_st = afp_pkg::st_run;
                end
            end
            // R13 reset never restarts
            afp_pkg::st_run: nxt_st = afp_pkg::st_run;
            default:         nxt_st = afp_pkg::st_por;
        endcase
        // R8 test on supply start
        if (!vdd) begin
            nxt_st = afp_pkg::st_por;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= afp_pkg::st_por;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // R11 phase length counter
    always_comb begin
        nxt_cnt = cnt_ff + 32'h1;
        // R9 short restarts phase
        if (nxt_st != st_ff || short_now || !testing) begin
            nxt_cnt = 32'h0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= 32'h0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // ------------------------------------------------------------------
    // Fault latches
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_q_ff <= 1'b0;
        end else begin
            rst_q_ff <= rst_n;
        end
    end

    always_comb begin
        nxt_ovl_latch = ovl_latch_ff;
        // R22 cleared by reset rise
        if (rst_rise) begin
            nxt_ovl_latch = '0;
        end
        // R18 power-on clear
        if (st_ff == afp_pkg::st_por) begin
            nxt_ovl_latch = '0;
        end
        // R5 overload latches, set wins
        if (running && rst_n) begin
            nxt_ovl_latch = nxt_ovl_latch | ovl;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ovl_latch_ff <= '0;
        end else begin
            ovl_latch_ff <= nxt_ovl_latch;
        end
    end

    // R17 thermal latch until reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ote_ff <= 1'b0;
        end else if (t155) begin
            ote_ff <= 1'b1;
        end else if (!rst_n && !testing) begin
            ote_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Shutdown decision
    // ------------------------------------------------------------------
    assign grp_ab   = |ovl_latch_ff[1:0];
    assign grp_cd   = |ovl_latch_ff[3:2];
    // R19 supply loss all Hi-Z
    // R20 supply return resumes
    // R23 reset low all Hi-Z
    assign glob_off = ~running | supply_low_protect | ote_ff | ~rst_n;

    always_comb begin
        nxt_hiz = {`AFP_NB{glob_off}};
        // R6 grouping by configuration
        if (cfg == afp_pkg::afp_par) begin
            nxt_hiz = nxt_hiz | {`AFP_NB{grp_ab | grp_cd}};
        end else begin
            nxt_hiz = nxt_hiz | {grp_cd, grp_cd, grp_ab, grp_ab};
        end
        // R7 bootstrap per half-bridge
        nxt_hiz = nxt_hiz | ~boot;
    end

    always_comb begin
        // R1 any shutdown fault
        nxt_sd = supply_low_protect | ote_ff | (|ovl_latch_ff) | (|(~boot)) |
                 (st_ff == afp_pkg::st_por);
        // R3 reset low releases flag
        if (!rst_n) begin
            nxt_sd = 1'b0;
        end
        // R12 test keeps flag low
        if (testing) begin
            nxt_sd = 1'b1;
        end
    end

    // R4 Hi-Z and flag together
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hiz                <= {`AFP_NB{1'b1}};
            shutdown_flag_n_oe <= 1'b0;
        end else begin
            hiz                <= nxt_hiz;
            shutdown_flag_n_oe <= nxt_sd;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            weak_pulldown   <= 1'b0;
            short_test_gnd  <= 1'b0;
            short_test_pvdd <= 1'b0;
        end else begin
            weak_pulldown   <= ~rst_n & running & (cfg != afp_pkg::afp_se);
            short_test_gnd  <= (nxt_st == afp_pkg::st_gnd);
            short_test_pvdd <= (nxt_st == afp_pkg::st_pvdd);
        end
    end

    // ------------------------------------------------------------------
    // Temperature warnings
    // ------------------------------------------------------------------
    // R2 warnings follow thresholds
    // R15 three levels on 64-pin
    // R16 two levels on 44-pin
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            temp_warning_n_oe      <= 1'b0;
            temp_warning_low_n_oe  <= 1'b0;
            temp_warning_high_n_oe <= 1'b0;
        end else begin
            temp_warning_n_oe      <= ~pkg64 & t125;
            temp_warning_low_n_oe  <= pkg64 & t100;
            temp_warning_high_n_oe <= pkg64 & t125;
        end
    end

    // R24 open-drain drive low only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            od_low_ff <= 1'b0;
        end else begin
            od_low_ff <= 1'b0;
        end
    end

    assign shutdown_flag_n_o     = od_low_ff;
    assign temp_warning_n_o      = od_low_ff;
    assign temp_warning_low_n_o  = od_low_ff;
    assign temp_warning_high_n_o = od_low_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_enter_pvdd;
        (st_ff == afp_pkg::st_pvdd) && ($past(st_ff) != afp_pkg::st_pvdd);
    endsequence

    sequence s_test_held;
        testing [*2];
    endsequence

    a_sd_on_uvp: assert property ( // R19
        (supply_low_protect && !testing && rst_n) |=> shutdown_flag_n_oe && (&hiz))
        else $error("undervoltage did not shut down");
    a_sd_ote: assert property ( // R1
        (ote_ff && rst_n) |=> shutdown_flag_n_oe && (&hiz))
        else $error("thermal latch did not shut down");
    a_warn_high: assert property ( // R2
        (pkg64 && t125) |=> temp_warning_high_n_oe && !temp_warning_n_oe)
        else $error("high warning wrong");
    a_rst_release: assert property ( // R3
        (!rst_n && !testing) |=> !shutdown_flag_n_oe && (&hiz))
        else $error("reset low did not release flag");
    a_test_order: assert property ( // R10
        s_enter_pvdd |-> $past(st_ff) == afp_pkg::st_gnd)
        else $error("supply phase not after ground phase");
    a_test_flag: assert property ( // R12
        s_test_held |=> shutdown_flag_n_oe && (&hiz))
        else $error("flag not low during short test");
    a_test_bound: assert property ( // R11
        testing |-> cnt_ff < 32'(SHORT_PHASE_CYC))
        else $error("phase counter overran");
    a_run_stays: assert property ( // R13
        (running && vdd) |=> running)
        else $error("short test restarted after start-up");
    a_se_skip: assert property ( // R14
        (st_ff == afp_pkg::st_por && supplies_ok &&
         cfg == afp_pkg::afp_se) |=> running)
        else $error("short test not skipped in single-ended");
    a_group_ab: assert property ( // R6
        (running && rst_n && !supply_low_protect && !ote_ff && (&boot) &&
         cfg == afp_pkg::afp_full && ovl_latch_ff == 4'h1) |=> hiz == 4'h3)
        else $error("wrong shutdown group");
    a_boot_local: assert property ( // R7
        (running && rst_n && !supply_low_protect && !ote_ff && ovl_latch_ff == 4'h0 &&
         boot == 4'hd) |=> hiz == 4'h2)
        else $error("bootstrap undervoltage not local");
    a_ote_hold: assert property ( // R17
        (ote_ff && rst_n) |=> ote_ff)
        else $error("thermal latch lost without reset");

endmodule : afp_fault_ctrl

// File: rtl/afp_input_sync.sv
// Two-flop synchronisers for every pin input of the block
`timescale 1ns/1ps
`include "afp_regs.svh"

module afp_input_sync #(
    parameter int W = `AFP_SYNC_W
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // Raw pin levels
    input  wire logic [W-1:0] raw,
    // Synchronised levels
    afp_sync_if.drv           sif
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] stab_ff;

    // ------------------------------------------------------------------
    // One synchroniser per bit
    // ------------------------------------------------------------------
    generate
        for (genvar i = 0; i < W; i++) begin : g_sync
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_ff[i] <= 1'b0;
                    stab_ff[i] <= 1'b0;
                end else begin
                    meta_ff[i] <= raw[i];
                    stab_ff[i] <= meta_ff[i];
                end
            end
        end
    endgenerate

    assign sif.lvl = stab_ff;

endmodule : afp_input_sync

// File: rtl/afp_pkg.sv
// Types of the fault-protection block
package afp_pkg;

    typedef enum logic [1:0] {
        afp_full,
        afp_par,
        afp_se
    } afp_cfg_t;

    typedef enum logic [1:0] {
        st_por,
        st_gnd,
        st_pvdd,
        st_run
    } afp_st_t;

endpackage : afp_pkg

// File: rtl/afp_regs.svh
// Bit positions, mode codes and timing counts of the fault-protection block
`ifndef AFP_REGS_SVH
`define AFP_REGS_SVH

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define AFP_CLK_MHZ          200
`define AFP_SHORT_MS_PER_UF  15
`define AFP_SHORT_CYC_PER_UF (`AFP_SHORT_MS_PER_UF * `AFP_CLK_MHZ * 1000)
`define AFP_FILTER_CAP_UF    1

// ------------------------------------------------------------------
// Sizes and mode pin codes
// ------------------------------------------------------------------
`define AFP_NB               4
`define AFP_CFG_W            2
`define AFP_CFG_FULL         2'h0
`define AFP_CFG_PAR          2'h1
`define AFP_CFG_SE           2'h2

// ------------------------------------------------------------------
// Positions in the synchronised input vector
// ------------------------------------------------------------------
`define AFP_SY_RST           0
`define AFP_SY_VDD           1
`define AFP_SY_GATE          2
`define AFP_SY_BOOT          6
`define AFP_SY_OVL           10
`define AFP_SY_SHG           14
`define AFP_SY_SHP           18
`define AFP_SY_T100          22
`define AFP_SY_T125          23
`define AFP_SY_T155          24
`define AFP_SY_CFG           25
`define AFP_SY_PKG           27
`define AFP_SYNC_W           28

`endif

// File: rtl/afp_sync_if.sv
// Synchronised pin levels passed from the input stage to the core
`timescale 1ns/1ps
`include "afp_regs.svh"

interface afp_sync_if;
    logic [`AFP_SYNC_W-1:0] lvl;
    modport drv (output lvl);
    modport sink (input lvl);
endinterface : afp_sync_if

// File: verification/afp_ctrl_model.sv
// Controller model that watches the fault flags and drives the reset pin
`timescale 1ns/1ps

module afp_ctrl_model #(
    parameter int GAP_CYC = 20
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Flag pins and bench request
    input  wire logic sd_pin,
    input  wire logic warn_pin,
    input  wire logic hold_low,
    // Reset pin and reaction
    output logic      reset_pin_n,
    output logic      volume_down
);
    int   gap_ff;
    logic sd_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gap_ff <= GAP_CYC;
            sd_ff  <= 1'b1;
        end else begin
            sd_ff <= sd_pin;
            if (sd_ff && !sd_pin)
                gap_ff <= 0;
            else if (gap_ff < GAP_CYC)
                gap_ff <= gap_ff + 1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            reset_pin_n <= 1'b1;
        else if (hold_low)
            reset_pin_n <= 1'b0;
        else if (gap_ff >= GAP_CYC)
            reset_pin_n <= 1'b1;
    end

    assign volume_down = !warn_pin;
endmodule : afp_ctrl_model

// File: verification/tb_top.sv
// Self-checking bench of the fault-protection block
`timescale 1ns/1ps
`include "afp_regs.svh"

module tb_top;
    localparam int PH  = 8;
    localparam int GAP = 20;
    logic       clk, arst_n, hold_low, pkg_64pin, vdd_ok, rst_pin_n;
    logic       t100, t125, t155, sd_o, sd_oe, tw_o, tw_oe;
    logic       lo_o, lo_oe, hi_o, hi_oe, seen, wp;
    logic [1:0] cfg_pins;
    logic [3:0] gate_ok, boot_ok, ovl, sh_gnd, sh_pvdd, hiz, expv;
    logic       st_gnd, st_pvdd;
    wire        sd_pin = sd_oe ? sd_o : 1'b1;
    wire        tw_pin = tw_oe ? tw_o : 1'b1;
    wire        lo_pin = lo_oe ? lo_o : 1'b1;
    wire        hi_pin = hi_oe ? hi_o : 1'b1;
    int         error_cnt, total_checks, cycles, i, m, b;

    afp_fault_ctrl #(.SHORT_PHASE_CYC(PH)) dut_u (
        .clk(clk), .arst_n(arst_n), .reset_pin_n(rst_pin_n),
        .cfg_pins(cfg_pins), .pkg_64pin(pkg_64pin), .vdd_ok(vdd_ok),
        .gate_supply_ok(gate_ok), .boot_ok(boot_ok), .overload_det(ovl),
        .temp_above_100(t100), .temp_above_125(t125),
        .temp_above_155(t155), .short_to_gnd(sh_gnd),
        .short_to_pvdd(sh_pvdd), .hiz(hiz), .weak_pulldown(wp),
        .short_test_gnd(st_gnd), .short_test_pvdd(st_pvdd),
        .shutdown_flag_n_o(sd_o), .shutdown_flag_n_oe(sd_oe),
        .temp_warning_n_o(tw_o), .temp_warning_n_oe(tw_oe),
        .temp_warning_low_n_o(lo_o), .temp_warning_low_n_oe(lo_oe),
        .temp_warning_high_n_o(hi_o), .temp_warning_high_n_oe(hi_oe));

    afp_ctrl_model #(.GAP_CYC(GAP)) ctrl_u (
        .clk(clk), .arst_n(arst_n), .sd_pin(sd_pin), .warn_pin(tw_pin),
        .hold_low(hold_low), .reset_pin_n(rst_pin_n), .volume_down());

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic wait_run();
        for (i = 0; i < 60 && hiz !== 4'h0; i++)
            cyc(1);
    endtask : wait_run

    task automatic scan_test(input int n);
        seen = 1'b0;
        repeat (n) begin
            cyc(1);
            seen = seen | st_gnd | st_pvdd;
        end
    endtask : scan_test

    task automatic pulse_reset();
        hold_low = 1'b1;
        cyc(5);
        hold_low = 1'b0;
        cyc(GAP + 12);
    endtask : pulse_reset

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        {arst_n, hold_low, pkg_64pin, vdd_ok, t100, t125, t155} = '0;
        {cfg_pins, gate_ok, boot_ok, ovl, sh_gnd, sh_pvdd} = '0;
        cyc(3);
        arst_n = 1'b1;
        vdd_ok = 1'b1;
        gate_ok = 4'hf;
        boot_ok = 4'hf;
        for (i = 0; i < 20 && st_gnd !== 1'b1; i++)
            cyc(1);
        chk(st_gnd, 1'b1);
        hold_low = 1'b1;
        cyc(4);
        chk(sd_pin, 1'b0);
        hold_low = 1'b0;
        for (i = 0; i < 20 && st_pvdd !== 1'b1; i++)
            cyc(1);
        chk({st_gnd, st_pvdd}, 4'h1);
        chk(hiz, 4'hf);
        for (i = 0; i < 20 && st_pvdd === 1'b1; i++)
            cyc(1);
        chk(8'(i), 8'(PH));
        wait_run();
        chk(hiz, 4'h0);
        chk(sd_pin, 1'b1);
        $display("test startup done");

        for (m = 0; m < 3; m++) begin
            for (b = 0; b < 4; b++) begin
                cfg_pins = 2'(m);
                ovl = 4'h1 << b;
                expv = (m == 1) ? 4'hf : ((b < 2) ? 4'h3 : 4'hc);
                cyc(6);
                chk(hiz, expv);
                chk(sd_pin, 1'b0);
                ovl = 4'h0;
                cyc(6);
                chk(hiz, expv);
                hold_low = 1'b1;
                cyc(5);
                chk(sd_pin, 1'b1);
                chk(hiz, 4'hf);
                chk(wp, m != 2);
                hold_low = 1'b0;
                cyc(GAP + 12);
                chk(hiz, 4'h0);
            end
        end
        cfg_pins = 2'h0;
        $display("test overload done");

        boot_ok = 4'hd;
        cyc(6);
        chk(hiz, 4'h2);
        chk(sd_pin, 1'b0);
        boot_ok = 4'hf;
        cyc(6);
        chk({sd_pin, hiz}, 5'h10);
        gate_ok = 4'h7;
        cyc(6);
        chk({sd_pin, hiz}, 5'h0f);
        gate_ok = 4'hf;
        cyc(6);
        chk({sd_pin, hiz}, 5'h10);
        sh_gnd = 4'hf;
        sh_pvdd = 4'hf;
        cyc(6);
        chk(hiz, 4'h0);
        {sh_gnd, sh_pvdd} = '0;
        $display("test supplies done");

        pkg_64pin = 1'b1;
        t100 = 1'b1;
        cyc(6);
        chk({tw_pin, lo_pin, hi_pin}, 3'h5);
        t125 = 1'b1;
        cyc(6);
        chk({tw_pin, lo_pin, hi_pin, sd_pin}, 4'h9);
        t155 = 1'b1;
        cyc(6);
        chk({sd_pin, hiz}, 5'h0f);
        {t100, t125, t155} = '0;
        cyc(6);
        chk({lo_pin, hi_pin, hiz}, 6'h3f);
        pulse_reset();
        chk({sd_pin, hiz}, 5'h10);
        scan_test(30);
        chk(seen, 1'b0);
        pkg_64pin = 1'b0;
        t100 = 1'b1;
        cyc(6);
        chk({tw_pin, lo_pin, hi_pin}, 3'h7);
        t125 = 1'b1;
        cyc(6);
        chk({tw_pin, lo_pin, hi_pin}, 3'h3);
        t155 = 1'b1;
        cyc(6);
        chk({sd_pin, hiz}, 5'h0f);
        {t100, t125, t155} = '0;
        pulse_reset();
        chk({tw_pin, hiz}, 5'h10);
        $display("test thermal done");

        ovl = 4'h1;
        cyc(6);
        ovl = 4'h0;
        vdd_ok = 1'b0;
        sh_gnd = 4'h4;
        cyc(6);
        chk({sd_pin, hiz}, 5'h0f);
        vdd_ok = 1'b1;
        cyc(3 * PH + 10);
        chk({st_pvdd, hiz}, 5'h0f);
        sh_gnd = 4'h0;
        wait_run();
        chk({sd_pin, hiz}, 5'h10);
        cfg_pins = 2'h2;
        vdd_ok = 1'b0;
        cyc(6);
        vdd_ok = 1'b1;
        scan_test(40);
        chk({seen, hiz}, 5'h00);
        $display("test short_test done");
        report_and_stop();
    end
endmodule : tb_top
